// ===== src/ocs_pkg.sv
package ocs_pkg;

  // Calibration store layout: trim, tempco default, seal
  localparam int CAL_BITS = 9;
  localparam int TRIM_W = 5;
  localparam int TEMPCO_W = 3;
  localparam int TRIM_LSB = 4;
  localparam int TEMPCO_LSB = 1;
  localparam int SEAL_POS = 0;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CONTRAST = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_SHIFT = 8'h10;
  localparam logic [7:0] ADDR_MULT = 8'h14;

  // Field positions
  localparam int CMD_DC_POS = 8;
  localparam int CTRL_PSAVE_POS = 0;
  localparam int ST_CAL_POS = 0;
  localparam int ST_BUSY_POS = 1;
  localparam int ST_DONE_POS = 2;
  localparam int ST_PUMP_LSB = 3;
  localparam int ST_SEAL_POS = 5;

  // Command byte encodings
  localparam logic [7:0] CMD_CAL_ENTRY = 8'h82;
  localparam logic [4:0] PWR_PREFIX = 5'h05;
  localparam int PWR_HI_POS = 2;
  localparam int PWR_LO_POS = 1;
  localparam int CONT_POS = 7;
  localparam int DATA_POS = 0;

  // Reset values
  localparam logic PSAVE_RST = 1'b1;
  localparam logic [7:0] CONTRAST_RST = 8'h00;
  localparam logic [1:0] PUMP_RST = 2'h0;
  localparam logic [8:0] SHIFT_RST = 9'h000;

  // Reload time of the non-volatile cells
  localparam int REFRESH_TIME_US = 5000;
  localparam int CLK_FREQ_MHZ = 100;
  localparam int REFRESH_CYCLES = REFRESH_TIME_US * CLK_FREQ_MHZ;

  // Command byte as it arrives from the interface
  typedef struct packed {
    logic dc_sel;
    logic [7:0] bits;
  } ocs_cmd_t;

  // Shift register view of the nine calibration bits
  typedef struct packed {
    logic [TRIM_W-1:0] trim;
    logic [TEMPCO_W-1:0] tempco;
    logic seal;
  } ocs_cal_t;

endpackage

// ===== src/ocs_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the clock domain
module ocs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ===== src/ocs_vop_sum.sv
`timescale 1ns/1ps
// Sums contrast with two signed 5-bit trims, clamped to 0..255
module ocs_vop_sum
  import ocs_pkg::*;
(
  input wire logic [7:0] contrast_i,
  input wire logic [TRIM_W-1:0] pad_trim_i,
  input wire logic [TRIM_W-1:0] cal_trim_i,
  output logic [7:0] sum_o
);
  logic signed [9:0] pad_ext;
  logic signed [9:0] cal_ext;
  logic signed [9:0] total;

  // Two's complement trims, sign extended to the adder width
  assign pad_ext = 10'(signed'(pad_trim_i));
  assign cal_ext = 10'(signed'(cal_trim_i));
  assign total = signed'({2'b00, contrast_i}) + pad_ext + cal_ext;
  // Final adder protects against both ends
  assign sum_o = total[9] ? 8'h00 :
                 (total > 10'sd255) ? 8'hFF : total[7:0];
endmodule

// ===== src/ocs_otp_ctrl.sv
`timescale 1ns/1ps
module ocs_otp_ctrl
  import ocs_pkg::*;
#(
  parameter int unsigned RELOAD_CYCLES = REFRESH_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [CAL_BITS-1:0] otp_cell_i,
  input wire logic [TRIM_W-1:0] glass_trim_pads_i,
  input wire logic prog_voltage_i,
  output logic [7:0] mult_ctrl_o,
  output logic [TEMPCO_W-1:0] tempco_sel_o,
  output logic [1:0] pump_ctrl_o,
  output logic otp_prog_en_o,
  output logic [CAL_BITS-1:0] otp_prog_data_o,
  output logic cal_mode_o
);
  localparam int CNT_W = $clog2(RELOAD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELOAD_CYCLES - 1);

  typedef enum logic {OCS_NORMAL, OCS_SHIFT} ocs_mode_t;

  ocs_mode_t mode;
  ocs_cal_t shift_reg;
  ocs_cmd_t cmd;
  logic power_save;
  logic [7:0] contrast;
  logic [1:0] pump;
  logic busy;
  logic refreshed;
  logic [CNT_W-1:0] cnt;
  logic [CAL_BITS-1:0] cells_s;
  logic [TRIM_W-1:0] pads_s;
  logic prog_v_s;
  logic [7:0] vop_sum;

  // Pins from outside the domain are synchronised first
  ocs_sync #(.WIDTH(CAL_BITS + TRIM_W + 1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({otp_cell_i, glass_trim_pads_i, prog_voltage_i}),
    .sync_o({cells_s, pads_s, prog_v_s})
  );

  // Multiplier value built from the live shift register
  ocs_vop_sum u_sum (
    .contrast_i(contrast),
    .pad_trim_i(pads_s),
    .cal_trim_i(shift_reg.trim),
    .sum_o(vop_sum)
  );

  // Bus decode
  logic req;
  logic wr_fire;
  logic rd_take;
  logic cmd_fire;
  logic ctrl_wr;
  logic contrast_wr;
  assign req = wb_cyc_i & wb_stb_i;
  // Writes take effect on the edge where ack is sampled high
  assign wr_fire = req & wb_we_i & wb_ack_o;
  assign rd_take = req & ~wb_ack_o;
  assign cmd = ocs_cmd_t'(wb_dat_i[CMD_DC_POS:0]);
  assign cmd_fire = wr_fire & (wb_adr_i == ADDR_CMD)
                    & (wb_sel_i[1:0] == 2'b11) & ~cmd.dc_sel;
  assign ctrl_wr = wr_fire & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0];
  assign contrast_wr = wr_fire & (wb_adr_i == ADDR_CONTRAST)
                       & wb_sel_i[0];

  // Command interpretation depends on the mode
  logic in_cal;
  logic shift_fire;
  logic shift_exit;
  logic entry_hit;
  logic entry_ok;
  logic pwr_hit;
  logic psave_exit;
  logic reload_req;
  logic reload_end;
  assign in_cal = (mode == OCS_SHIFT);
  assign shift_fire = cmd_fire & in_cal;
  assign shift_exit = shift_fire & ~cmd.bits[CONT_POS];
  assign entry_hit = cmd_fire & ~in_cal
                     & (cmd.bits == CMD_CAL_ENTRY);
  // Seal only trusted after a full reload
  assign entry_ok = refreshed & ~busy & ~shift_reg.seal;
  assign pwr_hit = cmd_fire & ~in_cal
                   & (cmd.bits[7:3] == PWR_PREFIX)
                   & cmd.bits[DATA_POS];
  assign psave_exit = ctrl_wr & power_save
                      & ~wb_dat_i[CTRL_PSAVE_POS];
  // In power-save the pump bits move but no reload starts
  assign reload_req = (pwr_hit & ~power_save) | psave_exit;
  assign reload_end = busy & (cnt == CNT_LAST);

  // Bus answer: one wait state, then ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= rd_take;
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  logic [31:0] rd_data;
  assign rd_data =
    (wb_adr_i == ADDR_CTRL) ? 32'(power_save) :
    (wb_adr_i == ADDR_CONTRAST) ? 32'(contrast) :
    (wb_adr_i == ADDR_STATUS) ?
      32'({shift_reg.seal, pump, refreshed, busy, in_cal}) :
    (wb_adr_i == ADDR_SHIFT) ? 32'(shift_reg) :
    (wb_adr_i == ADDR_MULT) ? 32'(mult_ctrl_o) : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_take) begin
      wb_dat_o <= rd_data;
    end
  end

  // Software controls, independent of a running reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_save <= PSAVE_RST;
      contrast <= CONTRAST_RST;
      pump <= PUMP_RST;
    end else begin
      if (ctrl_wr) begin
        power_save <= wb_dat_i[CTRL_PSAVE_POS];
      end
      if (contrast_wr) begin
        contrast <= wb_dat_i[7:0];
      end
      if (pwr_hit) begin
        pump <= {cmd.bits[PWR_HI_POS], cmd.bits[PWR_LO_POS]};
      end
    end
  end

  // Mode machine; reset drops straight back to normal
  ocs_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    case (mode)
      OCS_NORMAL: begin
        if (entry_hit & entry_ok) begin
          next_mode = OCS_SHIFT;
        end
      end
      OCS_SHIFT: begin
        if (shift_exit) begin
          next_mode = OCS_NORMAL;
        end
      end
      default: begin
        next_mode = OCS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= OCS_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // Reload timer; a new request restarts the full wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= '0;
      refreshed <= 1'b0;
    end else if (reload_req) begin
      busy <= 1'b1;
      cnt <= '0;
    end else if (reload_end) begin
      busy <= 1'b0;
      refreshed <= 1'b1;
    end else if (busy) begin
      cnt <= cnt + 1'b1;
    end
  end

  // Shift register: the only view of the cells
  // A finishing reload wins over a shift in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg <= ocs_cal_t'(SHIFT_RST);
    end else if (reload_end) begin
      shift_reg <= ocs_cal_t'(cells_s);
    end else if (shift_fire) begin
      // MSB first, seal lands last at bit 0
      shift_reg <= {shift_reg[CAL_BITS-2:0], cmd.bits[DATA_POS]};
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_ctrl_o <= 8'h00;
      tempco_sel_o <= '0;
      pump_ctrl_o <= PUMP_RST;
      otp_prog_en_o <= 1'b0;
      otp_prog_data_o <= '0;
      cal_mode_o <= 1'b0;
    end else begin
      mult_ctrl_o <= vop_sum;
      tempco_sel_o <= shift_reg.tempco;
      pump_ctrl_o <= pump;
      // Cells can only be burned inside the mode
      otp_prog_en_o <= in_cal & prog_v_s;
      otp_prog_data_o <= in_cal ? shift_reg : '0;
      cal_mode_o <= in_cal;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_entry_req;
    entry_hit & entry_ok;
  endsequence

  sequence s_shift_byte;
    shift_fire & ~reload_end;
  endsequence

  reset_clear_a: assert property (
    $past(rst_i) |-> (shift_reg == '0) && !in_cal && !refreshed)
    else $error("state not cleared after reset");

  enter_mode_a: assert property (
    s_entry_req |=> in_cal ##1 cal_mode_o)
    else $error("valid entry byte did not enter mode");

  entry_gate_a: assert property (
    (entry_hit & (busy | ~refreshed)) |=> !in_cal)
    else $error("entry taken before reload completed");

  seal_block_a: assert property (
    (entry_hit & shift_reg.seal) |=> !in_cal)
    else $error("entry taken with seal set");

  shift_in_a: assert property (
    s_shift_byte |=> shift_reg == {$past(shift_reg[7:0]),
                                   $past(cmd.bits[0])})
    else $error("shift data bit not taken");

  exit_mode_a: assert property (
    shift_fire & ~cmd.bits[CONT_POS] |=> !in_cal)
    else $error("exit byte did not leave mode");

  stay_mode_a: assert property (
    shift_fire & cmd.bits[CONT_POS] |=> in_cal && $stable(pump))
    else $error("continuation byte left mode");

  // A fresh request on the last count restarts the wait instead
  reload_copy_a: assert property (
    (reload_end & ~reload_req) |=> shift_reg == $past(cells_s) && !busy)
    else $error("reload did not copy the cells");

  psave_skip_a: assert property (
    (pwr_hit & power_save & ~busy) |=> !busy ##1
      pump_ctrl_o == $past(pump))
    else $error("reload started in power-save");

  prog_gate_a: assert property (
    otp_prog_en_o |-> $past(in_cal) && $past(prog_v_s))
    else $error("programming enabled outside mode");

  trim_zero_a: assert property (
    (shift_reg.trim == '0 && pads_s == '0 && $stable(contrast))
      |=> mult_ctrl_o == $past(contrast))
    else $error("zero trims changed the multiplier value");

  tempco_out_a: assert property (
    reload_end |=> ##1 tempco_sel_o == $past(cells_s[3:1], 2))
    else $error("tempco default not loaded");

  // Both routes into a reload start the timer at once
  psave_reload_a: assert property (
    psave_exit |=> busy)
    else $error("leaving power-save did not start a reload");

  pwr_reload_a: assert property (
    (pwr_hit & ~power_save) |=> busy)
    else $error("power command did not start a reload");

  busy_cmd_a: assert property (
    (busy & contrast_wr) |=> contrast == $past(wb_dat_i[7:0]))
    else $error("contrast write lost during reload");

  // Outside the mode nothing may reach the cells
  prog_off_a: assert property (
    !in_cal |=> !otp_prog_en_o && (otp_prog_data_o == '0))
    else $error("programming outputs active outside mode");

  shift_hold_a: assert property (
    (!reload_end & !shift_fire) |=> $stable(shift_reg))
    else $error("shift register changed without reload or shift");

  dc_ignore_a: assert property (
    (wr_fire & wb_dat_i[CMD_DC_POS]) |=> $stable(mode))
    else $error("data byte changed the mode");

  // A seal bit is only trusted once a reload has landed
  seal_trust_a: assert property (
    in_cal |-> refreshed)
    else $error("mode held without a completed reload");
endmodule

// ===== testbench/ocs_host_model.sv
`timescale 1ns/1ps
// Host controller: Wishbone classic master sending interface bytes
module ocs_host_model
  import ocs_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // Idle bus from time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'hFF;
    sel_o = 4'h0;
    dat_o = 32'hA5A5_A5A5;
  end

  // One classic cycle, held until ack is seen at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data must not keep showing the last value
    dat_o <= ~d;
  endtask

  // Nine bytes, trim msb first and seal last; only the last may exit
  task automatic shift9(input logic [8:0] v, input logic stay);
    logic [31:0] q;
    for (int i = 8; i >= 0; i--) begin
      bus(1'b1, ADDR_CMD, {24'h0, (i > 0) | stay, 6'h3F, v[i]}, q);
    end
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import ocs_pkg::*;
();
  logic clk, rst, ack, cyc, stb, we, pv, pen, calm;
  logic [7:0] adr, mult;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [8:0] cells, pdata;
  logic [4:0] pads;
  logic [2:0] tempco;
  logic [1:0] pump;
  int n_fail = 0;
  int check_count = 0;

  // Short reload count keeps the run brief
  ocs_otp_ctrl #(.RELOAD_CYCLES(20)) i_dut (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .otp_cell_i(cells), .glass_trim_pads_i(pads), .prog_voltage_i(pv),
    .mult_ctrl_o(mult), .tempco_sel_o(tempco), .pump_ctrl_o(pump),
    .otp_prog_en_o(pen), .otp_prog_data_o(pdata), .cal_mode_o(calm));

  ocs_host_model i_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a);
    i_host.bus(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.bus(1'b1, a, d, q);
  endtask
  task automatic cmd(input logic dc, input logic [7:0] b);
    wr(ADDR_CMD, {23'h0, dc, b});
  endtask
  // Registered outputs lag a write by up to three cycles
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wait_reload();
    int k = 0;
    rd(ADDR_STATUS);
    while (q[ST_BUSY_POS] !== 1'b0 && k < 100) begin
      rd(ADDR_STATUS);
      k++;
    end
    chk("reload busy", q[ST_BUSY_POS], 32'h0);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset();
    rd(ADDR_SHIFT);
    chk("shift at reset", q, 32'h0);
    cmd(1'b0, CMD_CAL_ENTRY);
    settle();
    chk("entry unrefreshed", calm, 32'h0);
  endtask

  // Leaving power-save reloads; entry is refused meanwhile but contrast writes still land
  task automatic t_reload();
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS);
    chk("busy", q[ST_BUSY_POS], 32'h1);
    cmd(1'b0, CMD_CAL_ENTRY);
    settle();
    chk("entry busy", calm, 32'h0);
    wr(ADDR_CONTRAST, 32'h10);
    rd(ADDR_CONTRAST);
    chk("contrast", q, 32'h10);
    wait_reload();
    rd(ADDR_SHIFT);
    chk("shift loaded", q, 32'h1C4);
    settle();
    chk("tempco", tempco, 32'h2);
    chk("mult", mult, 32'h0C);
  endtask

  task automatic t_shift();
    cmd(1'b1, CMD_CAL_ENTRY);
    settle();
    chk("entry dc high", calm, 32'h0);
    @(posedge clk);
    pv <= 1'b1;
    cmd(1'b0, CMD_CAL_ENTRY);
    settle();
    chk("entry", calm, 32'h1);
    chk("prog en", pen, 32'h1);
    i_host.shift9(9'h0FA, 1'b1);
    settle();
    chk("stay", calm, 32'h1);
    rd(ADDR_SHIFT);
    chk("shift data", q, 32'h0FA);
    chk("prog data", pdata, 32'h0FA);
    chk("live trim", mult, 32'h1F);
    wr(ADDR_CONTRAST, 32'hF5);
    settle();
    chk("clamp high", mult, 32'hFF);
    wr(ADDR_CONTRAST, 32'h02);
    i_host.shift9(9'h1C4, 1'b0);
    settle();
    chk("exit", calm, 32'h0);
    chk("prog off", pen, 32'h0);
    chk("clamp low", mult, 32'h0);
    cmd(1'b0, 8'h2D);
    settle();
    chk("pump", pump, 32'h2);
    rd(ADDR_STATUS);
    chk("refresh", q[ST_BUSY_POS], 32'h1);
    pv <= 1'b0;
    wait_reload();
  endtask

  task automatic t_seal();
    wr(ADDR_CTRL, 32'h1);
    cmd(1'b0, 8'h2B);
    settle();
    chk("pump psave", pump, 32'h1);
    rd(ADDR_STATUS);
    chk("no reload", q[ST_BUSY_POS], 32'h0);
    cells <= 9'h001;
    wr(ADDR_CTRL, 32'h0);
    wait_reload();
    cmd(1'b0, CMD_CAL_ENTRY);
    settle();
    chk("sealed", calm, 32'h0);
  endtask

  task automatic t_reset_mid();
    @(posedge clk);
    cells <= 9'h000;
    cmd(1'b0, 8'h29);
    wait_reload();
    cmd(1'b0, CMD_CAL_ENTRY);
    settle();
    chk("unsealed", calm, 32'h1);
    @(posedge clk);
    do_reset();
    #1;
    chk("reset exit", calm, 32'h0);
    rd(ADDR_SHIFT);
    chk("shift cleared", q, 32'h0);
    // Pad trim alone: the stored trim is zero after reset
    wr(ADDR_CONTRAST, 32'h20);
    pads <= 5'h1D;
    settle();
    chk("pad trim", mult, 32'h1D);
  endtask

  // Watchdog sized well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    pads = 5'h00;
    cells = 9'h1C4;
    pv = 1'b0;
    do_reset();
    t_reset();
    t_reload();
    t_shift();
    t_seal();
    t_reset_mid();
    conclude();
  end
endmodule
